// *** hw/pdr_regs.sv ***
// equaliser training and cable diagnostic register bank, classic wishbone slave
//
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/1ps
module pdr_regs
   import pdr_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [11:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic wb_err_o,
   // active-link diagnostic engine
   output logic diag_start_o,
   input wire logic diag_done_i,
   input wire logic [7:0] diag_sum_i,
   // reflectometry steering
   output logic refl_cross_en_o,
   output logic refl_tx_en_o,
   output logic refl_rx_en_o,
   output logic [6:0] refl_avg_cycles_o,
   output logic [3:0] refl_pulse_o,
   output logic [7:0] refl_listen_o,
   // equaliser steering
   output logic [15:0] eq_feedback_o,
   output logic [15:0] eq_bandwidth_o,
   output logic [14:0] eq_timing_thr_o,
   output logic [14:0] eq_linkup_thr_o,
   output logic [2:0] eq_timer1_o,
   output logic [5:0] eq_timer2_o,
   output logic [2:0] eq_timer3_o,
   output logic [2:0] eq_timer4_o,
   output logic [3:0] eq_gain_max_o,
   output logic [3:0] eq_gain_min_o,
   output logic eq_retrain_en_o,
   input wire logic eq_steady_i,
   input wire logic [14:0] eq_mse_i,
   output logic eq_recover_o,
   output logic irq_o
);

   logic [15:0] feq_r;
   logic [15:0] gbw_r;
   logic [14:0] bad_thr_r;
   logic [14:0] tl_thr_r;
   logic [14:0] lu_thr_r;
   logic [15:0] timers_r;
   logic [15:0] gidx_r;
   logic [15:0] retrain_r;
   logic [3:0] diag_low_r;
   // one-hot progress of the active-link diagnostic
   typedef enum logic [2:0] {
      DIAG_IDLE = 3'b001,
      DIAG_LAUNCH = 3'b010,
      DIAG_RUN = 3'b100
   } pdr_diag_state_t;
   pdr_diag_state_t diag_state_r;
   pdr_diag_state_t diag_state_nxt;
   logic diag_launch;
   logic diag_running;
   logic diag_busy;
   logic [7:0] diag_sum_r;
   logic [14:0] refl_r;
   logic [15:0] pulse_r;
   logic [15:0] listen_r;
   logic [1:0] irq_stat_r;
   logic [1:0] irq_mask_r;
   logic recover_r;
   logic ack_r;
   logic [31:0] rdat_r;

   logic req;
   logic wr;
   logic [9:0] idx;
   logic hit;
   logic hit_q;
   logic start_req;
   logic [15:0] wmask;
   logic [15:0] rd_val;
   logic [1:0] irq_evt;

   // merge byte-lane write data into a 16-bit register
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nw,
                                           input logic [15:0] m);
      merge16 = (old & ~m) | (nw & m);
   endfunction

   // write strobe for one register index, shared by every register process except the interrupt status and mask
   function automatic logic strobe(input logic go, input logic [9:0] cur,
                                   input logic [9:0] at);
      strobe = go && (cur == at);
   endfunction

   assign req = wb_cyc_i & wb_stb_i & ~ack_r;
   assign idx = wb_adr_i[11:2];
   assign wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

   always_comb begin
      hit = 1'b1;
      rd_val = 16'h0000;
      case (idx)
         IDX_FEEDBACK_EQUALIZER_CTRL: rd_val = feq_r;
         IDX_GAIN_BANDWIDTH_CTRL: rd_val = gbw_r;
         IDX_BAD_ERROR_THRESHOLD: rd_val = {1'b0, bad_thr_r};
         IDX_TIMING_LOOP_ERROR_THRESHOLD: rd_val = {1'b0, tl_thr_r};
         IDX_LINK_UP_ERROR_THRESHOLD: rd_val = {1'b0, lu_thr_r};
         IDX_EQUALIZER_TRAINING_TIMERS: rd_val = timers_r;
         IDX_GAIN_INDEX_LIMITS: rd_val = gidx_r;
         IDX_GAIN_RETRAIN_CTRL: rd_val = retrain_r;
         IDX_ACTIVE_LINK_DIAG_CTRL_RESULT:
            rd_val = {diag_launch, 2'b00, diag_busy, diag_sum_r, diag_low_r};
         IDX_REFLECTOMETRY_CTRL: rd_val = {1'b0, refl_r};
         IDX_REFLECTOMETRY_PULSE_CTRL: rd_val = pulse_r;
         IDX_REFLECTOMETRY_LISTEN_CTRL: rd_val = listen_r;
         IDX_IRQ_STATUS: rd_val = {14'h0000, irq_stat_r};
         IDX_IRQ_MASK: rd_val = {14'h0000, irq_mask_r};
         default: hit = 1'b0;
      endcase
   end

   assign wr = req & wb_we_i & hit;

   // one wait state: ack in the cycle after the request is seen
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
         rdat_r <= 32'h0000_0000;
      end else begin
         ack_r <= req;
         rdat_r <= {16'h0000, rd_val};
      end
   end

   assign wb_ack_o = ack_r & wb_cyc_i & wb_stb_i & hit_q;
   assign wb_err_o = ack_r & wb_cyc_i & wb_stb_i & ~hit_q;
   assign wb_dat_o = rdat_r;

   // ack or err must follow the index of the cycle being answered
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hit_q <= 1'b0;
      end else begin
         hit_q <= hit;
      end
   end

   // equaliser configuration, one process per register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         feq_r <= RST_FEEDBACK_EQUALIZER_CTRL;
      end else if (strobe(wr, idx, IDX_FEEDBACK_EQUALIZER_CTRL)) begin
         feq_r <= merge16(feq_r, wb_dat_i[15:0], wmask);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         gbw_r <= RST_GAIN_BANDWIDTH_CTRL;
      end else if (strobe(wr, idx, IDX_GAIN_BANDWIDTH_CTRL)) begin
         gbw_r <= merge16(gbw_r, wb_dat_i[15:0], wmask);
      end
   end

   // thresholds keep 15 bits; bit 15 is not stored and reads zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bad_thr_r <= RST_BAD_ERROR_THRESHOLD;
      end else if (strobe(wr, idx, IDX_BAD_ERROR_THRESHOLD)) begin
         bad_thr_r <= 15'(merge16({1'b0, bad_thr_r}, wb_dat_i[15:0], wmask));
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tl_thr_r <= RST_TIMING_LOOP_ERROR_THRESHOLD;
      end else if (strobe(wr, idx, IDX_TIMING_LOOP_ERROR_THRESHOLD)) begin
         tl_thr_r <= 15'(merge16({1'b0, tl_thr_r}, wb_dat_i[15:0], wmask));
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lu_thr_r <= RST_LINK_UP_ERROR_THRESHOLD;
      end else if (strobe(wr, idx, IDX_LINK_UP_ERROR_THRESHOLD)) begin
         lu_thr_r <= 15'(merge16({1'b0, lu_thr_r}, wb_dat_i[15:0], wmask));
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         timers_r <= RST_EQUALIZER_TRAINING_TIMERS;
      end else if (strobe(wr, idx, IDX_EQUALIZER_TRAINING_TIMERS)) begin
         timers_r <= merge16(timers_r, wb_dat_i[15:0], wmask);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         gidx_r <= RST_GAIN_INDEX_LIMITS;
      end else if (strobe(wr, idx, IDX_GAIN_INDEX_LIMITS)) begin
         gidx_r <= merge16(gidx_r, wb_dat_i[15:0], wmask);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         retrain_r <= RST_GAIN_RETRAIN_CTRL;
      end else if (strobe(wr, idx, IDX_GAIN_RETRAIN_CTRL)) begin
         retrain_r <= merge16(retrain_r, wb_dat_i[15:0], wmask);
      end
   end

   // reflectometry configuration, one process per register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         refl_r <= RST_REFLECTOMETRY_CTRL;
      end else if (strobe(wr, idx, IDX_REFLECTOMETRY_CTRL)) begin
         refl_r <= 15'(merge16({1'b0, refl_r}, wb_dat_i[15:0], wmask));
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pulse_r <= RST_REFLECTOMETRY_PULSE_CTRL;
      end else if (strobe(wr, idx, IDX_REFLECTOMETRY_PULSE_CTRL)) begin
         pulse_r <= merge16(pulse_r, wb_dat_i[15:0], wmask);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         listen_r <= RST_REFLECTOMETRY_LISTEN_CTRL;
      end else if (strobe(wr, idx, IDX_REFLECTOMETRY_LISTEN_CTRL)) begin
         listen_r <= merge16(listen_r, wb_dat_i[15:0], wmask);
      end
   end

   // low nibble of the diagnostic register is plain storage
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         diag_low_r <= RST_DIAG_LOW;
      end else if (strobe(wr, idx, IDX_ACTIVE_LINK_DIAG_CTRL_RESULT) && wb_sel_i[0]) begin
         diag_low_r <= wb_dat_i[3:0];
      end
   end

   // launch lasts one cycle, then the test runs until the engine reports done;
   // a start written while a test is in flight is dropped
   assign start_req = strobe(wr, idx, IDX_ACTIVE_LINK_DIAG_CTRL_RESULT) && wb_sel_i[1]
                      && wb_dat_i[DIAG_START_BIT];

   always_comb begin
      diag_state_nxt = diag_state_r;
      case (diag_state_r)
         DIAG_IDLE: begin
            if (start_req) begin
               diag_state_nxt = DIAG_LAUNCH;
            end
         end
         DIAG_LAUNCH: begin
            diag_state_nxt = DIAG_RUN;
         end
         DIAG_RUN: begin
            if (diag_done_i) begin
               diag_state_nxt = DIAG_IDLE;
            end
         end
         default: begin
            diag_state_nxt = DIAG_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         diag_state_r <= DIAG_IDLE;
      end else begin
         diag_state_r <= diag_state_nxt;
      end
   end

   assign diag_launch = (diag_state_r == DIAG_LAUNCH);
   assign diag_running = (diag_state_r == DIAG_RUN);
   assign diag_busy = (diag_state_r != DIAG_IDLE);

   // sum is captured once, as the engine reports completion
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         diag_sum_r <= 8'h00;
      end else if (diag_running && diag_done_i) begin
         diag_sum_r <= diag_sum_i;
      end
   end

   // steady-state exit on bad error
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         recover_r <= 1'b0;
      end else begin
         recover_r <= eq_steady_i && (eq_mse_i > bad_thr_r);
      end
   end

   // sticky events; a new event beats a write-one clear
   assign irq_evt[IRQ_DIAG_DONE] = diag_running & diag_done_i;
   assign irq_evt[IRQ_BAD_ERROR] = recover_r;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_stat_r <= 2'b00;
         irq_mask_r <= 2'b00;
      end else begin
         if (wr && idx == IDX_IRQ_STATUS && wb_sel_i[0]) begin
            irq_stat_r <= (irq_stat_r & ~wb_dat_i[1:0]) | irq_evt;
         end else begin
            irq_stat_r <= irq_stat_r | irq_evt;
         end
         if (wr && idx == IDX_IRQ_MASK && wb_sel_i[0]) begin
            irq_mask_r <= wb_dat_i[1:0];
         end
      end
   end

   assign irq_o = |(irq_stat_r & irq_mask_r);

   // averaging: reserved code falls back to 64
   logic [2:0] avg_code;
   assign avg_code = (refl_r[AVG_LSB +: 3] == AVG_RESERVED) ? AVG_MAX
                                                             : refl_r[AVG_LSB +: 3];
   assign refl_avg_cycles_o = 7'(7'h01 << avg_code);

   assign diag_start_o = diag_launch;
   assign refl_cross_en_o = ~refl_r[CROSS_DIS_BIT];
   assign refl_tx_en_o = ~refl_r[TX_BYPASS_BIT];
   assign refl_rx_en_o = ~refl_r[RX_BYPASS_BIT];
   assign refl_pulse_o = pulse_r[3:0];
   assign refl_listen_o = listen_r[LISTEN_LSB +: 8];
   assign eq_feedback_o = feq_r;
   assign eq_bandwidth_o = gbw_r;
   assign eq_timing_thr_o = tl_thr_r;
   assign eq_linkup_thr_o = lu_thr_r;
   assign eq_timer1_o = timers_r[TIMER1_LSB +: 3];
   assign eq_timer2_o = timers_r[TIMER2_LSB +: 6];
   assign eq_timer3_o = timers_r[TIMER3_LSB +: 3];
   assign eq_timer4_o = timers_r[2:0];
   assign eq_gain_max_o = gidx_r[MAX_GAIN_LSB +: 4];
   assign eq_gain_min_o = gidx_r[3:0];
   assign eq_retrain_en_o = ~retrain_r[RETRAIN_DIS_BIT];
   assign eq_recover_o = recover_r;

endmodule

// *** hw/pdr_pkg.sv ***
// constants for the equaliser and cable diagnostic register bank
package pdr_pkg;
   // register offsets, kept as indices; byte address is four times the index
   localparam logic [9:0] IDX_FEEDBACK_EQUALIZER_CTRL = 10'h114;
   localparam logic [9:0] IDX_GAIN_BANDWIDTH_CTRL = 10'h116;
   localparam logic [9:0] IDX_BAD_ERROR_THRESHOLD = 10'h121;
   localparam logic [9:0] IDX_TIMING_LOOP_ERROR_THRESHOLD = 10'h122;
   localparam logic [9:0] IDX_LINK_UP_ERROR_THRESHOLD = 10'h123;
   localparam logic [9:0] IDX_EQUALIZER_TRAINING_TIMERS = 10'h126;
   localparam logic [9:0] IDX_GAIN_INDEX_LIMITS = 10'h129;
   localparam logic [9:0] IDX_GAIN_RETRAIN_CTRL = 10'h130;
   localparam logic [9:0] IDX_ACTIVE_LINK_DIAG_CTRL_RESULT = 10'h155;
   localparam logic [9:0] IDX_REFLECTOMETRY_CTRL = 10'h170;
   localparam logic [9:0] IDX_REFLECTOMETRY_PULSE_CTRL = 10'h171;
   localparam logic [9:0] IDX_REFLECTOMETRY_LISTEN_CTRL = 10'h173;
   localparam logic [9:0] IDX_IRQ_STATUS = 10'h1f0;
   localparam logic [9:0] IDX_IRQ_MASK = 10'h1f1;

   // reset values
   localparam logic [15:0] RST_FEEDBACK_EQUALIZER_CTRL = 16'h400a;
   localparam logic [15:0] RST_GAIN_BANDWIDTH_CTRL = 16'h014a;
   localparam logic [14:0] RST_BAD_ERROR_THRESHOLD = 15'h199a;
   localparam logic [14:0] RST_TIMING_LOOP_ERROR_THRESHOLD = 15'h1027;
   localparam logic [14:0] RST_LINK_UP_ERROR_THRESHOLD = 15'h051c;
   localparam logic [15:0] RST_EQUALIZER_TRAINING_TIMERS = 16'h461b;
   localparam logic [15:0] RST_GAIN_INDEX_LIMITS = 16'h000f;
   localparam logic [15:0] RST_GAIN_RETRAIN_CTRL = 16'h0001;
   localparam logic [3:0] RST_DIAG_LOW = 4'h1;
   localparam logic [14:0] RST_REFLECTOMETRY_CTRL = 15'h0e52;
   localparam logic [15:0] RST_REFLECTOMETRY_PULSE_CTRL = 16'hc85c;
   localparam logic [15:0] RST_REFLECTOMETRY_LISTEN_CTRL = 16'hff1e;

   // field positions
   localparam int DIAG_START_BIT = 15;
   localparam int DIAG_BUSY_BIT = 12;
   localparam int DIAG_SUM_LSB = 4;
   localparam int CROSS_DIS_BIT = 14;
   localparam int TX_BYPASS_BIT = 13;
   localparam int RX_BYPASS_BIT = 12;
   localparam int AVG_LSB = 8;
   localparam int RETRAIN_DIS_BIT = 11;
   localparam int MAX_GAIN_LSB = 4;
   localparam int TIMER1_LSB = 12;
   localparam int TIMER2_LSB = 6;
   localparam int TIMER3_LSB = 3;
   localparam int LISTEN_LSB = 8;
   localparam logic [2:0] AVG_RESERVED = 3'h7;
   localparam logic [2:0] AVG_MAX = 3'h6;

   // interrupt status bits
   localparam int IRQ_DIAG_DONE = 0;
   localparam int IRQ_BAD_ERROR = 1;
endpackage

// *** sim/pdr_regs_props.sv ***
// port-level assertions for the equaliser and cable diagnostic register bank
`timescale 1ns/1ps
module pdr_regs_props
   import pdr_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic wb_err_o,
   input wire logic diag_start_o,
   input wire logic refl_cross_en_o,
   input wire logic refl_tx_en_o,
   input wire logic refl_rx_en_o,
   input wire logic [6:0] refl_avg_cycles_o,
   input wire logic [3:0] refl_pulse_o,
   input wire logic [7:0] refl_listen_o,
   input wire logic eq_steady_i,
   input wire logic eq_recover_o
);
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   a_one_wait_answer: assert property ($rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o ^ wb_err_o)
      else $error("request not answered after one wait state");
   a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   a_no_ack_err: assert property (!(wb_ack_o && wb_err_o))
      else $error("ack and err together");
   a_upper_read_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
      else $error("upper read data not zero");
   a_start_from_write: assert property (
      diag_start_o |-> $past(wb_cyc_i && wb_stb_i && wb_we_i && wb_dat_i[15]) ##1 !diag_start_o)
      else $error("start pulse without start write or not self clearing");
   a_recover_needs_steady: assert property (!eq_steady_i |=> !eq_recover_o)
      else $error("recovery raised outside steady state");
   a_avg_one_hot: assert property ($onehot(refl_avg_cycles_o))
      else $error("average count not a single power of two");
   a_refl_write_only: assert property (
      $changed({refl_cross_en_o, refl_tx_en_o, refl_rx_en_o, refl_pulse_o, refl_listen_o})
      |-> wb_ack_o && $past(wb_we_i))
      else $error("reflectometry setting changed without a write");
endmodule

bind pdr_regs pdr_regs_props u_props (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
   .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .diag_start_o, .refl_cross_en_o, .refl_tx_en_o,
   .refl_rx_en_o, .refl_avg_cycles_o, .refl_pulse_o, .refl_listen_o, .eq_steady_i,
   .eq_recover_o);

// *** sim/pdr_regs_tb.sv ***
// self-checking bench for the register bank
`timescale 1ns/1ps
`define CHK(g, x) begin num_checks++; if ((g) !== (x)) begin miscompares++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x); end end
module pdr_regs_tb
   import pdr_pkg::*;
;
   logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, e;
   logic diag_done_i = 0, eq_steady_i = 0, diag_start_o, wb_ack_o, wb_err_o, irq_o;
   logic refl_cross_en_o, refl_tx_en_o, refl_rx_en_o, eq_retrain_en_o, eq_recover_o;
   logic [11:0] wb_adr_i = 0;
   logic [3:0] wb_sel_i = 0, refl_pulse_o, eq_gain_max_o, eq_gain_min_o;
   logic [31:0] wb_dat_i = 0, wb_dat_o, q;
   logic [7:0] diag_sum_i = 0, refl_listen_o, sv;
   logic [14:0] eq_mse_i = 0, eq_timing_thr_o, eq_linkup_thr_o;
   logic [15:0] eq_feedback_o, eq_bandwidth_o, d;
   logic [6:0] refl_avg_cycles_o;
   logic [2:0] eq_timer1_o, eq_timer3_o, eq_timer4_o;
   logic [5:0] eq_timer2_o;
   logic [1:0] s;
   int miscompares = 0, num_checks = 0, seed = 32'h24a1_90a4, starts = 0, k;
   localparam logic [9:0] WI[11] = '{10'h114, 10'h116, 10'h121, 10'h122, 10'h123, 10'h126,
      10'h129, 10'h130, 10'h170, 10'h171, 10'h173};
   localparam logic [15:0] RV[11] = '{16'h400a, 16'h014a, 16'h199a, 16'h1027, 16'h051c,
      16'h461b, 16'h000f, 16'h0001, 16'h0e52, 16'hc85c, 16'hff1e};
   logic [15:0] sh[11];
   wire [107:0] outs = {eq_feedback_o, eq_bandwidth_o, eq_timing_thr_o, eq_linkup_thr_o,
      eq_timer1_o, eq_timer2_o, eq_timer3_o, eq_timer4_o, eq_gain_max_o, eq_gain_min_o,
      eq_retrain_en_o, refl_cross_en_o, refl_tx_en_o, refl_rx_en_o, refl_avg_cycles_o,
      refl_pulse_o, refl_listen_o};

   pdr_regs dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
      .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .diag_start_o, .diag_done_i, .diag_sum_i,
      .refl_cross_en_o, .refl_tx_en_o, .refl_rx_en_o, .refl_avg_cycles_o, .refl_pulse_o,
      .refl_listen_o, .eq_feedback_o, .eq_bandwidth_o, .eq_timing_thr_o, .eq_linkup_thr_o,
      .eq_timer1_o, .eq_timer2_o, .eq_timer3_o, .eq_timer4_o, .eq_gain_max_o,
      .eq_gain_min_o, .eq_retrain_en_o, .eq_steady_i, .eq_mse_i, .eq_recover_o, .irq_o);

   always #2.5 clk_i = ~clk_i;
   always @(posedge clk_i) if (diag_start_o === 1'b1) starts++;

   function automatic logic [6:0] avg_exp(input logic [2:0] c);
      return (c == 3'h7) ? 7'h40 : 7'h01 << c;
   endfunction
   function automatic logic [107:0] outs_exp();
      return {sh[0], sh[1], sh[3][14:0], sh[4][14:0], sh[5][14:0], sh[6][7:0], ~sh[7][11],
         ~sh[8][14:12], avg_exp(sh[8][10:8]), sh[9][3:0], sh[10][15:8]};
   endfunction

   // classic cycle; only the watchdog ends the wait on a hung slave
   task automatic xfer(input logic w, input logic [9:0] a, input logic [15:0] dd,
         input logic [1:0] ss);
      wb_cyc_i <= 1;
      wb_stb_i <= 1;
      wb_we_i <= w;
      wb_adr_i <= {a, 2'b00};
      wb_sel_i <= {2'b00, ss};
      wb_dat_i <= {16'($random(seed)), dd};
      do begin
         @(posedge clk_i);
      end while (!(wb_ack_o || wb_err_o));
      q = wb_dat_o;
      e = wb_err_o;
      wb_cyc_i <= 0;
      wb_stb_i <= 0;
      @(posedge clk_i);
   endtask
   task automatic wr(input logic [9:0] a, input logic [15:0] dd);
      xfer(1'b1, a, dd, 2'b11);
   endtask
   task automatic rd(input logic [9:0] a, input logic [31:0] x);
      xfer(1'b0, a, 16'h0000, 2'b11);
      `CHK(q, x)
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   initial begin
      repeat (5000) @(posedge clk_i);
      miscompares++;
      report_and_stop();
   end

   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 0;
      @(posedge clk_i);
      foreach (RV[i]) rd(WI[i], {16'h0000, RV[i]});
      sh = RV;
      `CHK(outs, outs_exp())
      rd(10'h155, 32'h0000_0001);
      $display("reset values done");
      repeat (40) begin
         k = {$random(seed)} % 11;
         d = 16'($random(seed));
         s = 2'($random(seed));
         xfer(1'b1, WI[k], d, s);
         if (s[0]) sh[k][7:0] = d[7:0];
         if (s[1]) sh[k][15:8] = d[15:8];
         rd(WI[k], {16'h0000, sh[k] & ((k inside {2, 3, 4, 8}) ? 16'h7fff : 16'hffff)});
         `CHK(outs, outs_exp())
      end
      for (int c = 0; c < 8; c++) begin
         wr(10'h170, {5'h00, 3'(c), 8'h52});
         `CHK(refl_avg_cycles_o, avg_exp(3'(c)))
      end
      xfer(1'b1, 10'h115, 16'hffff, 2'b11);
      `CHK(e, 1'b1)
      rd(10'h115, 32'h0000_0000);
      $display("random access done");
      wr(10'h1f1, 16'h0001);
      wr(10'h155, 16'h8001);
      `CHK(starts, 1)
      rd(10'h155, 32'h0000_1001);
      wr(10'h155, 16'h8001);
      `CHK(starts, 1)
      sv = 8'($random(seed));
      diag_sum_i <= sv;
      diag_done_i <= 1;
      @(posedge clk_i);
      diag_done_i <= 0;
      rd(10'h155, {16'h0000, 4'h0, sv, 4'h1});
      `CHK(irq_o, 1'b1)
      rd(10'h1f0, 32'h0000_0001);
      wr(10'h1f0, 16'h0001);
      `CHK(irq_o, 1'b0)
      $display("diagnostic done");
      wr(10'h121, 16'h0100);
      eq_steady_i <= 1;
      eq_mse_i <= 15'h0100;
      repeat (2) @(posedge clk_i);
      `CHK(eq_recover_o, 1'b0)
      eq_mse_i <= 15'h0101;
      repeat (2) @(posedge clk_i);
      `CHK(eq_recover_o, 1'b1)
      eq_steady_i <= 0;
      @(posedge clk_i);
      rd(10'h1f0, 32'h0000_0002);
      `CHK(irq_o, 1'b0)
      $display("recovery done");
      report_and_stop();
   end
endmodule
